/* hdl/ovh_port_params.svh */
// Timing counts and reset values of the serial overhead port.
// Assumes the system clock runs at 10 MHz and the fifo depth is a power of two.
`ifndef OVH_PORT_PARAMS_SVH
`define OVH_PORT_PARAMS_SVH

// System clock period in nanoseconds.
`define SYS_CLK_PERIOD_NS 100
// Overhead clock period in nanoseconds.
`define OVH_CLK_PERIOD_NS 800
// System clocks per overhead clock, rounded down.
`define OVH_CLK_CYCLES (`OVH_CLK_PERIOD_NS / `SYS_CLK_PERIOD_NS)
// Divider counter reset value.
`define OVH_DIV_RST 3'h0
// Receive fifo depth in words.
`define OVH_FIFO_DEPTH 4

`endif

/* hdl/ovh_port_pkg.sv */
// Types shared by the serial overhead port and its bench.
// Assumes ovh_port_params.svh holds all numeric constants.
package ovh_port_pkg;

  // Framing modes; none means clear channel, the port is idle.
  typedef enum logic [2:0] {
    FMT_NONE,
    FMT_T3_CBIT,
    FMT_T3_M23,
    FMT_E3_G751,
    FMT_E3_G832
  } fmt_t;

  // One overhead bit with its start-of-sequence flag.
  typedef struct packed {
    logic first;
    logic value;
  } ovh_bit_t;

  // Polarity inversion controls, one per overhead port signal.
  typedef struct packed {
    logic tx_data;
    logic tx_en;
    logic tx_clk;
    logic tx_start;
    logic rx_data;
    logic rx_clk;
    logic rx_start;
  } ovh_inv_t;

endpackage

/* hdl/ovh_fifo.sv */
// Small flip-flop fifo with valid and ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
module ovh_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        push;
  logic        pop;

  // Honest full and empty flags from the occupancy count.
  assign in_ready  = st_reg.cnt != (PW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data  = st_reg.mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update; push and pop may happen together.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr             = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

/* hdl/tdm_overhead_port.sv */
// Serial overhead insertion and extraction port of one framer port.
// Assumes the framer offers one overhead bit slot at a time on the transmit
// side and pushes received overhead bits into the receive side; the external
// overhead logic runs on the overhead clocks this block drives.
`include "ovh_port_params.svh"

module tdm_overhead_port (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Configuration
  input  wire ovh_port_pkg::fmt_t     framing_mode,
  input  wire ovh_port_pkg::ovh_inv_t pol_invert,
  // Framer transmit side: generated overhead bit in, merged bit out
  input  wire ovh_port_pkg::ovh_bit_t tx_gen_bit,
  input  wire logic                  tx_gen_valid,
  output logic                       tx_gen_ready,
  output ovh_port_pkg::ovh_bit_t      tx_merged_bit,
  output logic                       tx_merged_valid,
  // Framer receive side: received overhead bits in
  input  wire ovh_port_pkg::ovh_bit_t rx_ext_bit,
  input  wire logic                  rx_ext_valid,
  output logic                       rx_ext_ready,
  // Transmit overhead pins
  input  wire logic                  tx_ovh_data_in,
  input  wire logic                  tx_ovh_bit_enable,
  output logic                       tx_ovh_clk_out,
  output logic                       tx_ovh_seq_start,
  // Receive overhead pins
  output logic                       rx_ovh_data_out,
  output logic                       rx_ovh_clk_out,
  output logic                       rx_ovh_seq_start
);
  import ovh_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Constants and state

  // Divider terminal count and the count at which the clock goes high.
  localparam logic [2:0] DIV_LAST = 3'(`OVH_CLK_CYCLES - 1);
  localparam logic [2:0] DIV_HALF = 3'(`OVH_CLK_CYCLES / 2);

  typedef struct packed {
    logic [2:0] div_cnt;
    logic       ovh_clk;
    logic       d_meta;
    logic       d_sync;
    logic       e_meta;
    logic       e_sync;
    logic       pend_valid;
    logic       pend_first;
    logic       pend_bit;
    logic       tx_start;
    logic       out_valid;
    logic       out_first;
    logic       out_bit;
    logic       rx_data;
    logic       rx_start;
  } port_state_t;

  localparam port_state_t ST_RST = '{div_cnt: `OVH_DIV_RST, default: 1'b0};

  port_state_t st_reg;
  port_state_t st_next;
  logic        fmt_on;
  logic        fall;
  logic        data_s;
  logic        en_s;
  logic        fifo_valid;
  ovh_bit_t    fifo_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Derived strobes

  // The port works only while a framing mode is selected.
  assign fmt_on = framing_mode != FMT_NONE;
  // One-cycle pulse in the cycle before the overhead clock falls.
  assign fall   = fmt_on && (st_reg.div_cnt == DIV_LAST);
  // Synchronised pin inputs with their polarity removed.
  assign data_s = st_reg.d_sync ^ pol_invert.tx_data;
  assign en_s   = st_reg.e_sync ^ pol_invert.tx_en;
  // The framer's next overhead slot is taken at each falling edge.
  assign tx_gen_ready = fall;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer

  // Received overhead bits wait here; the framer stalls when it is full.
  ovh_fifo #(
    .WIDTH($bits(ovh_bit_t)),
    .DEPTH(`OVH_FIFO_DEPTH)
  ) rx_buf (
    .clk      (clk),
    .srst     (srst),
    .in_valid (rx_ext_valid),
    .in_data  (rx_ext_bit),
    .in_ready (rx_ext_ready),
    .out_valid(fifo_valid),
    .out_data (fifo_bit),
    .out_ready(fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Divider, pin sampling, transmit merge and receive shift-out.
  always_comb begin
    st_next           = st_reg;
    st_next.d_meta    = tx_ovh_data_in;
    st_next.d_sync    = st_reg.d_meta;
    st_next.e_meta    = tx_ovh_bit_enable;
    st_next.e_sync    = st_reg.e_meta;
    st_next.out_valid = 1'b0;
    if (!fmt_on) begin
      // Clear channel: port idle, framer bits pass untouched elsewhere.
      st_next.div_cnt    = `OVH_DIV_RST;
      st_next.ovh_clk    = 1'b0;
      st_next.pend_valid = 1'b0;
      st_next.tx_start   = 1'b0;
      st_next.rx_data    = 1'b0;
      st_next.rx_start   = 1'b0;
    end else begin
      // Slow overhead clock divided from the system clock.
      st_next.div_cnt = fall ? `OVH_DIV_RST : st_reg.div_cnt + 3'h1;
      st_next.ovh_clk = st_next.div_cnt >= DIV_HALF;
      if (fall) begin
        // Close the bit that ran since the last fall, sampled at this edge.
        if (st_reg.pend_valid) begin
          st_next.out_valid = 1'b1;
          st_next.out_first = st_reg.pend_first;
          // Enabled bits come from the pin, others keep the framer value.
          st_next.out_bit = en_s ? data_s : st_reg.pend_bit;
        end
        // Open the next bit; the marker flags the first slot of a sequence.
        st_next.pend_valid = tx_gen_valid;
        st_next.pend_first = tx_gen_valid && tx_gen_bit.first;
        st_next.pend_bit   = tx_gen_bit.value;
        st_next.tx_start   = tx_gen_valid && tx_gen_bit.first;
        // Shift out one received bit per clock, whatever its kind.
        st_next.rx_data  = fifo_valid && fifo_bit.value;
        st_next.rx_start = fifo_valid && fifo_bit.first;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Pins leave the flops through their own polarity control.
  assign tx_ovh_clk_out   = st_reg.ovh_clk ^ pol_invert.tx_clk;
  assign tx_ovh_seq_start = st_reg.tx_start ^ pol_invert.tx_start;
  assign rx_ovh_clk_out   = st_reg.ovh_clk ^ pol_invert.rx_clk;
  assign rx_ovh_data_out  = st_reg.rx_data ^ pol_invert.rx_data;
  assign rx_ovh_seq_start = st_reg.rx_start ^ pol_invert.rx_start;
  // Merged transmit bit back to the framer.
  assign tx_merged_valid       = st_reg.out_valid;
  assign tx_merged_bit.first   = st_reg.out_first;
  assign tx_merged_bit.value   = st_reg.out_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Transmit marker moves only with a falling overhead clock.
  tx_start_edge_a: assert property (@(posedge clk) disable iff (srst)
    $changed(st_reg.tx_start) && fmt_on |-> $past(fall) && !st_reg.ovh_clk)
    else $error("transmit start marker changed away from a falling edge");

  // Receive outputs move only with a falling overhead clock.
  rx_out_edge_a: assert property (@(posedge clk) disable iff (srst)
    ($changed(st_reg.rx_data) || $changed(st_reg.rx_start)) && fmt_on
      |-> $past(fall) && !st_reg.ovh_clk)
    else $error("receive outputs changed away from a falling edge");

  // One falling edge per eight system clocks.
  fall_spacing_a: assert property (@(posedge clk) disable iff (srst)
    fall |=> (!fall)[*7])
    else $error("overhead clock falls too often");

  // Overhead clock stays high four cycles once it rises.
  clk_high_time_a: assert property (@(posedge clk) disable iff (srst)
    $rose(st_reg.ovh_clk) |-> (st_reg.ovh_clk || !fmt_on)[*4])
    else $error("overhead clock high phase too short");

  // Enabled bits take the sampled pin value.
  tx_insert_a: assert property (@(posedge clk) disable iff (srst)
    fall && st_reg.pend_valid && en_s
      |=> st_reg.out_valid && (st_reg.out_bit == $past(data_s)))
    else $error("enabled overhead bit not taken from pin");

  // Disabled bits keep the framer value.
  tx_keep_a: assert property (@(posedge clk) disable iff (srst)
    fall && st_reg.pend_valid && !en_s
      |=> st_reg.out_valid && (st_reg.out_bit == $past(st_reg.pend_bit)))
    else $error("disabled overhead bit lost its framer value");

  // Pins are sampled only at a falling edge.
  tx_sample_time_a: assert property (@(posedge clk) disable iff (srst)
    st_reg.out_valid |-> $past(fall))
    else $error("transmit bit closed away from a falling edge");

  // A marked first slot shows the marker and closes eight clocks later as first.
  tx_seq_first_a: assert property (@(posedge clk) disable iff (srst)
    fall && tx_gen_valid && tx_gen_bit.first
      |=> st_reg.tx_start ##8 (st_reg.out_valid && st_reg.out_first) || !fmt_on)
    else $error("transmit sequence start misplaced");

  // A first received bit raises the receive marker at the falling edge.
  rx_seq_first_a: assert property (@(posedge clk) disable iff (srst)
    fall && fifo_valid && fifo_bit.first |=> st_reg.rx_start && !st_reg.ovh_clk)
    else $error("receive start marker missing");

  // Nothing moves on the pins while the port is idle.
  idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
    !fmt_on |=> !st_reg.ovh_clk && !st_reg.tx_start && !st_reg.rx_data && !st_reg.rx_start)
    else $error("overhead pins moved while the port is idle");

  // Overhead clock stays low four cycles once it falls.
  clk_low_time_a: assert property (@(posedge clk) disable iff (srst)
    $fell(st_reg.ovh_clk) && fmt_on |-> (!st_reg.ovh_clk)[*4])
    else $error("overhead clock low phase too short");

  // The sampling strobe lines up with the falling overhead clock.
  clk_fall_edge_a: assert property (@(posedge clk) disable iff (srst)
    fall |=> $fell(st_reg.ovh_clk) || !fmt_on)
    else $error("sampling strobe away from the clock fall");

  // A popped received bit is what the data pin shows next.
  rx_data_source_a: assert property (@(posedge clk) disable iff (srst)
    fall && fifo_valid |=> st_reg.rx_data == $past(fifo_bit.value))
    else $error("receive data pin lost the popped bit");

  // An empty buffer at a fall leaves both receive outputs low.
  rx_empty_zero_a: assert property (@(posedge clk) disable iff (srst)
    fall && !fifo_valid |=> !st_reg.rx_data && !st_reg.rx_start)
    else $error("receive outputs not cleared on an empty slot");

  // Only a first received bit raises the receive marker.
  rx_marker_first_a: assert property (@(posedge clk) disable iff (srst)
    fall && fifo_valid && !fifo_bit.first |=> !st_reg.rx_start)
    else $error("receive marker raised on a later bit");

  // The first flag of a slot travels with its merged bit.
  tx_first_carry_a: assert property (@(posedge clk) disable iff (srst)
    fall && st_reg.pend_valid |=> st_reg.out_first == $past(st_reg.pend_first))
    else $error("first flag lost on the merged bit");

  // An empty slot produces no merged bit, so payload is never touched.
  tx_empty_slot_a: assert property (@(posedge clk) disable iff (srst)
    fall && !st_reg.pend_valid |=> !st_reg.out_valid)
    else $error("merged bit produced for an empty slot");

  // The transmit marker drops when the new slot is not a first bit.
  tx_marker_clear_a: assert property (@(posedge clk) disable iff (srst)
    fall && !(tx_gen_valid && tx_gen_bit.first) |=> !st_reg.tx_start)
    else $error("transmit marker held past the first slot");

  // A merged bit is handed back for one cycle only.
  merged_pulse_a: assert property (@(posedge clk) disable iff (srst)
    st_reg.out_valid |=> !st_reg.out_valid)
    else $error("merged bit valid for more than one cycle");

  // The enable pin reaches the merge through exactly two flops.
  en_sync_path_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(srst, 2) |-> en_s == ($past(tx_ovh_bit_enable, 2) ^ pol_invert.tx_en))
    else $error("enable pin path is not two flops deep");

  // The data pin reaches the merge through exactly two flops.
  data_sync_path_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(srst, 2) |-> data_s == ($past(tx_ovh_data_in, 2) ^ pol_invert.tx_data))
    else $error("data pin path is not two flops deep");

endmodule

/* verification/ovh_ext_logic.sv */
// Model of the external overhead logic beside one overhead port.
// Assumes the overhead clock pins are not inverted while it is in use.
module ovh_ext_logic (
  // Transmit pins
  input  wire logic       tx_ovh_clk_out,
  input  wire logic       tx_ovh_seq_start,
  output logic            tx_ovh_data_in,
  output logic            tx_ovh_bit_enable,
  // Values to insert, by position in the sequence
  input  wire logic [7:0] tx_pat_data,
  input  wire logic [7:0] tx_pat_en,
  // Receive pins and what was captured
  input  wire logic       rx_ovh_clk_out,
  input  wire logic       rx_ovh_data_out,
  input  wire logic       rx_ovh_seq_start,
  output logic [7:0]      rx_bits,
  output logic [3:0]      rx_idx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] tx_idx;

  // Quiet pins until the first overhead clock.
  initial begin
    tx_idx = 3'h7;
    tx_ovh_data_in = 1'b0;
    tx_ovh_bit_enable = 1'b0;
    rx_bits = 8'h00;
    rx_idx = 4'h8;
  end

  // The marker restarts the position, then one bit per rising edge.
  always @(posedge tx_ovh_clk_out) begin
    tx_idx = tx_ovh_seq_start ? 3'h0 : tx_idx + 3'h1;
    tx_ovh_data_in <= tx_pat_data[tx_idx];
    tx_ovh_bit_enable <= tx_pat_en[tx_idx];
  end

  // Capture on the rising edge; eight bits from each marker are kept.
  always @(posedge rx_ovh_clk_out) begin
    if (rx_ovh_seq_start) begin
      rx_bits <= {7'h00, rx_ovh_data_out};
      rx_idx <= 4'h1;
    end else if (rx_idx < 4'h8) begin
      rx_bits[rx_idx[2:0]] <= rx_ovh_data_out;
      rx_idx <= rx_idx + 4'h1;
    end
  end
endmodule

/* verification/tdm_overhead_port_tb_top.sv */
// Self-checking bench of the serial overhead port.
// Assumes ovh_ext_logic stands on the pins and the framer side is driven here.
`include "ovh_port_params.svh"

module tdm_overhead_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ovh_port_pkg::*;

  logic       clk, srst, tx_gen_valid, tx_gen_ready, tx_merged_valid, rx_ext_valid, rx_ext_ready;
  logic       tx_ovh_data_in, tx_ovh_bit_enable, tx_ovh_clk_out, tx_ovh_seq_start;
  logic       rx_ovh_data_out, rx_ovh_clk_out, rx_ovh_seq_start;
  fmt_t       framing_mode;
  ovh_inv_t   pol_invert;
  ovh_bit_t   tx_gen_bit, tx_merged_bit, rx_ext_bit;
  logic [7:0] tx_pat_data, tx_pat_en, rx_bits, merged_val, merged_first;
  logic [3:0] rx_idx;
  int         miscompares, compares, cycles, merged_n;
  fmt_t       modes[4] = '{FMT_T3_CBIT, FMT_T3_M23, FMT_E3_G751, FMT_E3_G832};

  tdm_overhead_port i_tdm_overhead_port (.clk, .srst, .framing_mode, .pol_invert, .tx_gen_bit, .tx_gen_valid,
    .tx_gen_ready, .tx_merged_bit, .tx_merged_valid, .rx_ext_bit, .rx_ext_valid, .rx_ext_ready,
    .tx_ovh_data_in, .tx_ovh_bit_enable, .tx_ovh_clk_out, .tx_ovh_seq_start, .rx_ovh_data_out,
    .rx_ovh_clk_out, .rx_ovh_seq_start);
  ovh_ext_logic i_ovh_ext_logic (.tx_ovh_clk_out, .tx_ovh_seq_start, .tx_ovh_data_in, .tx_ovh_bit_enable,
    .tx_pat_data, .tx_pat_en, .rx_ovh_clk_out, .rx_ovh_data_out, .rx_ovh_seq_start, .rx_bits, .rx_idx);

  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle count with a ceiling that cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      miscompares++;
      end_of_test;
    end
  end

  // Collect up to eight merged bits, sampled mid-cycle where the pulse has settled.
  always @(negedge clk) begin
    if (tx_merged_valid === 1'b1 && merged_n < 8) begin
      merged_val[merged_n] = tx_merged_bit.value;
      merged_first[merged_n] = tx_merged_bit.first;
      merged_n++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Runs eight transmit slots; the pins replace only the enabled bits.
  task automatic tx_seq(input fmt_t m, input logic [7:0] gen, input logic [7:0] d, input logic [7:0] en);
    logic [7:0] e, v;
    int t0;
    e = en ^ {8{pol_invert.tx_en}};
    v = d ^ {8{pol_invert.tx_data}};
    framing_mode = m;
    tx_pat_data = d;
    tx_pat_en = en;
    merged_n = 0;
    for (int i = 0; i < 8; i++) begin
      tx_gen_bit = '{first: (i == 0), value: gen[i]};
      tx_gen_valid = 1'b1;
      // Ready is a pulse in the cycle before the take edge.
      while (tx_gen_ready !== 1'b1) begin
        @(posedge clk);
        #10;
      end
      @(posedge clk);
      #10;
    end
    tx_gen_valid = 1'b0;
    repeat (12) @(posedge clk);
    #10;
    check("merged count", 8'h08, 8'(merged_n));
    check("merged values", (e & v) | (~e & gen), merged_val);
    check("merged first", 8'h01, merged_first);
    @(posedge tx_ovh_clk_out);
    t0 = cycles;
    @(posedge tx_ovh_clk_out);
    check("tx clock period", 8'(`OVH_CLK_CYCLES), 8'(cycles - t0));
    #10;
  endtask

  // Pushes eight received bits as fast as the fifo allows and checks the pins.
  task automatic rx_seq(input fmt_t m, input logic [7:0] bits);
    int refused;
    refused = 0;
    framing_mode = m;
    for (int i = 0; i < 8; i++) begin
      rx_ext_bit = '{first: (i == 0), value: bits[i]};
      rx_ext_valid = 1'b1;
      while (rx_ext_ready !== 1'b1) begin
        refused++;
        @(posedge clk);
        #10;
      end
      @(posedge clk);
      #10;
    end
    rx_ext_valid = 1'b0;
    repeat (80) @(posedge clk);
    #10;
    check("rx bits", bits, rx_bits);
    check("rx bit count", 8'h08, {4'h0, rx_idx});
    check("rx fifo refused", 8'h01, {7'h00, refused > 0});
    check("rx idle pins", 8'h00, {6'h00, rx_ovh_data_out, rx_ovh_seq_start});
  endtask

  // Idle port with all pins inverted: every output pin stands at its inverted rest level, framer strobes low.
  task automatic idle_check;
    int bad;
    bad = 0;
    framing_mode = FMT_NONE;
    pol_invert = '1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #10;
      if ({tx_ovh_clk_out, tx_ovh_seq_start, rx_ovh_data_out, rx_ovh_clk_out, rx_ovh_seq_start,
           tx_gen_ready, tx_merged_valid} !== 7'h7c) begin
        bad++;
      end
    end
    check("idle inverted pins", 8'h00, 8'(bad));
    pol_invert = '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    srst = 1'b1;
    framing_mode = FMT_NONE;
    pol_invert = '0;
    tx_gen_bit = '0;
    tx_gen_valid = 1'b0;
    rx_ext_bit = '0;
    rx_ext_valid = 1'b0;
    tx_pat_data = 8'h00;
    tx_pat_en = 8'h00;
    repeat (12) @(posedge clk);
    #10;
    check("reset outputs", 8'h01, {tx_ovh_clk_out, tx_ovh_seq_start, rx_ovh_data_out, rx_ovh_clk_out,
                                   rx_ovh_seq_start, tx_merged_valid, tx_gen_ready, rx_ext_ready});
    srst = 1'b0;
    foreach (modes[i]) begin
      tx_seq(modes[i], 8'ha5 ^ 8'(i), 8'h3c + 8'(i * 17), 8'h0f << i);
      rx_seq(modes[i], 8'h96 ^ 8'(i * 3));
    end
    pol_invert = 7'h60;
    tx_seq(FMT_E3_G832, 8'h5a, 8'hc3, 8'h33);
    pol_invert = '0;
    idle_check;
    end_of_test;
  end
endmodule
